//--- common/riv_defines.svh
`ifndef RIV_DEFINES_SVH
`define RIV_DEFINES_SVH

// Vector addresses, high byte location; the low byte sits one above
`define RIV_VEC_RESET     16'hfffe
`define RIV_VEC_IRQ1      16'hfffc
`define RIV_VEC_IRQ2      16'hfffa
`define RIV_VEC_IRQ3      16'hfff8
`define RIV_VEC_IRQ4      16'hfff6
`define RIV_VEC_IRQ5      16'hfff4
`define RIV_VEC_LSB       16'h0001

// Sequence lengths in state cycles
`define RIV_INIT_CYCLES   5'h11
`define RIV_IRQ_CYCLES    5'h13
`define RIV_IDLE_CYCLES   5'h11

// Countdown points inside a sequence
`define RIV_VEC_RD_HI     5'h04
`define RIV_VEC_RD_LO     5'h03
`define RIV_VEC_CAP_HI    5'h02
`define RIV_VEC_CAP_LO    5'h01

// Reset values
`define RIV_SP_RESET      8'h01
`define RIV_PORTB_RESET   8'hff

// Control register layout: per source an enable bit and a flag/clear bit
`define RIV_CTL_EN_OFS    0
`define RIV_CTL_FLAG_OFS  1
`define RIV_CTL_STRIDE    2
`define RIV_FIRST_IRQS    3

`endif

//--- common/riv_pkg.sv
package riv_pkg;
  // Sequencer states
  typedef enum {S_SEQ, S_RUN} riv_state_t;
  // Interrupt index, zero is the highest priority
  typedef logic [2:0]  riv_irq_idx_t;
  // Program memory address
  typedef logic [15:0] riv_addr_t;
endpackage : riv_pkg

//--- rtl/riv_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module riv_sync3 #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] fall_o
);
  logic [W-1:0] s1;          // Metastable stage, read only by s2
  logic [W-1:0] s2;          // Second stage
  logic [W-1:0] s3;          // Third stage
  logic [W-1:0] next_level;  // Filtered level

  // A bit changes only when stages two and three agree
  always_comb begin
    next_level = (s2 & ~(s2 ^ s3)) | (level_o & (s2 ^ s3));
  end

  // Pins idle high, so reset to ones avoids a false falling edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1      <= '1;
      s2      <= '1;
      s3      <= '1;
      level_o <= '1;
      fall_o  <= '0;
    end else if (ce_i) begin
      s1      <= d_i;
      s2      <= s1;
      s3      <= s2;
      level_o <= next_level;
      fall_o  <= level_o & ~next_level;
    end
  end
endmodule : riv_sync3
`default_nettype wire

//--- rtl/riv_prio.sv
`timescale 1ns/10ps
`default_nettype none
`include "riv_defines.svh"
module riv_prio #(
  parameter int NUM_IRQ = 5
) (
  input  wire logic [4:0]    req_i,
  output logic               any_o,
  output riv_pkg::riv_irq_idx_t idx_o,
  output riv_pkg::riv_addr_t vec_o,
  output logic [4:0]         onehot_o
);
  // Vector high-byte address for each source
  function automatic riv_pkg::riv_addr_t vec_of(input riv_pkg::riv_irq_idx_t idx);
    unique case (idx)
      3'h0:    vec_of = `RIV_VEC_IRQ1;
      3'h1:    vec_of = `RIV_VEC_IRQ2;
      3'h2:    vec_of = `RIV_VEC_IRQ3;
      3'h3:    vec_of = `RIV_VEC_IRQ4;
      3'h4:    vec_of = `RIV_VEC_IRQ5;
      default: vec_of = `RIV_VEC_RESET;  // Codes 5..7 never occur
    endcase
  endfunction : vec_of

  // Scan from the lowest priority up so the lowest index wins
  always_comb begin
    any_o = 1'b0;
    idx_o = 3'h0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = 3'(i);
      end
    end
    vec_o    = vec_of(idx_o);
    onehot_o = any_o ? 5'(5'h01 << idx_o) : 5'h00;
  end
endmodule : riv_prio
`default_nettype wire

//--- rtl/riv_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "riv_defines.svh"
module riv_top #(
  parameter int       NUM_IRQ      = 5,     // 3 or 5 maskable interrupts
  parameter bit       NMOS_VARIANT = 1'b1   // Selects port latch reset behaviour
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        por_n_i,
  input  wire logic        ce_i,
  input  wire logic        ext_irq_one_n_i,
  input  wire logic        ext_irq_three_n_i,
  input  wire logic        timer_one_uf_i,
  input  wire logic        timer_two_uf_i,
  input  wire logic        timer_three_uf_i,
  input  wire logic        rx_loaded_i,
  input  wire logic        tx_empty_i,
  input  wire logic        gie_i,
  input  wire logic        boundary_i,
  input  wire logic        idle_i,
  input  wire logic [15:0] pc_i,
  input  wire logic [7:0]  vec_data_i,
  input  wire logic        ctl_first_wr_i,
  input  wire logic [7:0]  ctl_first_wdata_i,
  input  wire logic        ctl_second_wr_i,
  input  wire logic [7:0]  ctl_second_wdata_i,
  output logic      [7:0]  ctl_first_rdata_o,
  output logic      [7:0]  ctl_second_rdata_o,
  output logic      [4:0]  irq_pending_flag_o,
  output logic             ddr_clear_o,
  output logic             port_a_set_o,
  output logic             port_cd_set_o,
  output logic             port_b_force_o,
  output logic      [7:0]  port_b_value_o,
  output logic             run_o,
  output logic             st_clr_o,
  output logic             push_o,
  output logic             sp_load_o,
  output logic      [7:0]  sp_value_o,
  output logic             saved_load_o,
  output logic      [7:0]  saved_pc_high_reg_o,
  output logic      [7:0]  saved_pc_low_reg_o,
  output logic             vec_rd_o,
  output logic      [15:0] vec_addr_o,
  output logic             pc_load_o,
  output logic      [15:0] pc_value_o,
  output logic             irq_ack_o,
  output logic      [2:0]  irq_code_o
);
  logic [1:0]             rst_pipe;      // Reset release synchroniser
  logic                   rst_q;         // Synchronised reset, active low
  logic [1:0]             por_pipe;      // Power-on release synchroniser
  logic                   por_q;         // Synchronised power-on reset
  logic [1:0]             ext_level;     // Filtered external pin levels
  logic [1:0]             ext_fall;      // Active edges on external pins
  logic [4:0]             irq_en;        // Per-source enables
  logic [4:0]             set_ev;        // Hardware set events
  logic [4:0]             clr_ev;        // Software and acknowledge clears
  logic [4:0]             wr_clr;        // Clear bits from control writes
  logic [4:0]             req;           // Qualified requests
  logic                   win_any;       // Some request qualifies
  riv_pkg::riv_irq_idx_t  win_idx;       // Winning source
  riv_pkg::riv_addr_t     win_vec;       // Winner's vector address
  logic [4:0]             win_onehot;    // Winner as a mask
  logic                   take;          // Acknowledge this cycle
  riv_pkg::riv_state_t    state;         // Sequencer state
  logic [4:0]             cnt;           // Cycles left in the sequence
  riv_pkg::riv_addr_t     seq_vec;       // Vector address being fetched
  logic                   seq_first;     // First cycle after reset release
  logic [7:0]             vec_hi_byte;   // Captured vector high byte
  logic [15:0]            pc_shadow;     // Last running program counter
  logic [4:0]             seq_age;       // Cycles since sequence start
  logic [4:0]             seq_len;       // Expected length of this sequence

  // Reset asserts at once and releases through two flops; the far end must
  // hold it long enough for the state clock to see it
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe <= 2'h0;
    end else if (ce_i) begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_q = rst_pipe[1];

  // Power-on reset only; it is the sole reset of the pending flags
  always_ff @(posedge core_clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      por_pipe <= 2'h0;
    end else if (ce_i) begin
      por_pipe <= {por_pipe[0], 1'b1};
    end
  end
  assign por_q = por_pipe[1];

  // Port defaults are held for as long as reset is in force
  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      ddr_clear_o    <= 1'b1;
      port_a_set_o   <= 1'b1;
      port_cd_set_o  <= NMOS_VARIANT;
      port_b_force_o <= 1'b1;
      port_b_value_o <= `RIV_PORTB_RESET;
    end else if (ce_i) begin
      ddr_clear_o    <= 1'b0;
      port_a_set_o   <= 1'b0;
      port_cd_set_o  <= 1'b0;
      port_b_force_o <= 1'b0;
    end
  end

  // External pins are asynchronous and active low
  riv_sync3 #(.W(2)) u_pin_sync (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_q),
    .ce_i    (ce_i),
    .d_i     ({ext_irq_three_n_i, ext_irq_one_n_i}),
    .level_o (ext_level),
    .fall_o  (ext_fall)
  );

  // Source map of set events
  always_comb begin
    set_ev[0] = ext_fall[0];
    set_ev[1] = timer_one_uf_i;
    set_ev[2] = ext_fall[1];
    set_ev[3] = rx_loaded_i | tx_empty_i | timer_three_uf_i;
    set_ev[4] = timer_two_uf_i;
  end

  // Clear bits share the flag positions in the control registers
  always_comb begin
    wr_clr = 5'h00;
    for (int k = 0; k < `RIV_FIRST_IRQS; k++) begin
      wr_clr[k] = ctl_first_wr_i &
                  ctl_first_wdata_i[k*`RIV_CTL_STRIDE + `RIV_CTL_FLAG_OFS];
    end
    for (int k = `RIV_FIRST_IRQS; k < 5; k++) begin
      wr_clr[k] = ctl_second_wr_i &
                  ctl_second_wdata_i[(k-`RIV_FIRST_IRQS)*`RIV_CTL_STRIDE
                                     + `RIV_CTL_FLAG_OFS];
    end
    clr_ev = wr_clr | (take ? win_onehot : 5'h00);
  end

  // Pulse latches; system reset does not touch them, a set beats a clear
  for (genvar g = 0; g < 5; g++) begin : g_flag
    if (g < NUM_IRQ) begin : g_live
      always_ff @(posedge core_clk_i or negedge por_q) begin
        if (!por_q) begin
          irq_pending_flag_o[g] <= 1'b0;
        end else if (ce_i) begin
          if (set_ev[g]) begin
            irq_pending_flag_o[g] <= 1'b1;
          end else if (clr_ev[g]) begin
            irq_pending_flag_o[g] <= 1'b0;
          end
        end
      end
    end else begin : g_absent
      // Small variant has no sources four and five
      always_ff @(posedge core_clk_i or negedge por_q) begin
        if (!por_q) begin
          irq_pending_flag_o[g] <= 1'b0;
        end else if (ce_i) begin
          irq_pending_flag_o[g] <= 1'b0;
        end
      end
    end
  end

  // Enables are zeroed by reset and written whole by the control registers
  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      irq_en <= 5'h00;
    end else if (ce_i) begin
      for (int k = 0; k < `RIV_FIRST_IRQS; k++) begin
        if (ctl_first_wr_i) begin
          irq_en[k] <= ctl_first_wdata_i[k*`RIV_CTL_STRIDE + `RIV_CTL_EN_OFS];
        end
      end
      for (int k = `RIV_FIRST_IRQS; k < 5; k++) begin
        if (ctl_second_wr_i && NUM_IRQ > `RIV_FIRST_IRQS) begin
          irq_en[k] <= ctl_second_wdata_i[(k-`RIV_FIRST_IRQS)*`RIV_CTL_STRIDE
                                          + `RIV_CTL_EN_OFS];
        end
      end
    end
  end

  // Read back shows enables and latched flags
  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      ctl_first_rdata_o  <= 8'h00;
      ctl_second_rdata_o <= 8'h00;
    end else if (ce_i) begin
      ctl_first_rdata_o  <= 8'h00;
      ctl_second_rdata_o <= 8'h00;
      for (int k = 0; k < `RIV_FIRST_IRQS; k++) begin
        ctl_first_rdata_o[k*`RIV_CTL_STRIDE + `RIV_CTL_EN_OFS]   <= irq_en[k];
        ctl_first_rdata_o[k*`RIV_CTL_STRIDE + `RIV_CTL_FLAG_OFS] <= irq_pending_flag_o[k];
      end
      for (int k = `RIV_FIRST_IRQS; k < 5; k++) begin
        ctl_second_rdata_o[(k-`RIV_FIRST_IRQS)*`RIV_CTL_STRIDE + `RIV_CTL_EN_OFS]
          <= irq_en[k];
        ctl_second_rdata_o[(k-`RIV_FIRST_IRQS)*`RIV_CTL_STRIDE + `RIV_CTL_FLAG_OFS]
          <= irq_pending_flag_o[k];
      end
    end
  end

  // Qualified requests and fixed priority
  assign req = irq_pending_flag_o & irq_en & {5{gie_i}};

  riv_prio #(.NUM_IRQ(NUM_IRQ)) u_prio (
    .req_i    (req),
    .any_o    (win_any),
    .idx_o    (win_idx),
    .vec_o    (win_vec),
    .onehot_o (win_onehot)
  );

  // Taken only at an instruction boundary, or at once out of idle
  assign take = (state == riv_pkg::S_RUN) && win_any && (boundary_i || idle_i);

  // Sequencer; reset lands directly at the start of the init count
  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      state   <= riv_pkg::S_SEQ;
      cnt     <= `RIV_INIT_CYCLES - 5'h01;
      seq_vec <= `RIV_VEC_RESET;
      seq_len <= `RIV_INIT_CYCLES;
    end else if (ce_i) begin
      unique case (state)
        riv_pkg::S_SEQ: begin
          if (cnt == 5'h00) begin
            state <= riv_pkg::S_RUN;
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
        riv_pkg::S_RUN: begin
          if (take) begin
            // Boundary cycle counts as the first of the sequence
            state   <= riv_pkg::S_SEQ;
            cnt     <= (idle_i ? `RIV_IDLE_CYCLES : `RIV_IRQ_CYCLES) - 5'h02;
            seq_len <= idle_i ? `RIV_IDLE_CYCLES : `RIV_IRQ_CYCLES;
            seq_vec <= win_vec;
          end
        end
      endcase
    end
  end

  // Program counter shadow survives system reset for the save
  always_ff @(posedge core_clk_i or negedge por_q) begin
    if (!por_q) begin
      pc_shadow <= 16'h0000;
    end else if (ce_i && run_o) begin
      pc_shadow <= pc_i;
    end
  end

  // Saving the old program counter right after release
  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      seq_first           <= 1'b1;
      saved_load_o        <= 1'b0;
      saved_pc_high_reg_o <= 8'h00;
      saved_pc_low_reg_o  <= 8'h00;
    end else if (ce_i) begin
      seq_first    <= 1'b0;
      saved_load_o <= seq_first;
      if (seq_first) begin
        saved_pc_high_reg_o <= pc_shadow[15:8];
        saved_pc_low_reg_o  <= pc_shadow[7:0];
      end
    end
  end

  // Commands to the core; status clear and stack load hold through reset
  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      run_o       <= 1'b0;
      st_clr_o    <= 1'b1;
      sp_load_o   <= 1'b1;
      sp_value_o  <= `RIV_SP_RESET;
      push_o      <= 1'b0;
      irq_ack_o   <= 1'b0;
      irq_code_o  <= 3'h0;
      vec_rd_o    <= 1'b0;
      vec_addr_o  <= 16'h0000;
      vec_hi_byte <= 8'h00;
      pc_load_o   <= 1'b0;
      pc_value_o  <= 16'h0000;
    end else if (ce_i) begin
      st_clr_o  <= take;
      push_o    <= take;
      irq_ack_o <= take;
      sp_load_o <= 1'b0;
      if (take) begin
        irq_code_o <= win_idx;
      end
      // Two vector reads, the high byte first
      vec_rd_o <= (state == riv_pkg::S_SEQ) &&
                  (cnt == `RIV_VEC_RD_HI || cnt == `RIV_VEC_RD_LO);
      vec_addr_o <= (cnt == `RIV_VEC_RD_HI) ? seq_vec : (seq_vec | `RIV_VEC_LSB);
      if (state == riv_pkg::S_SEQ && cnt == `RIV_VEC_CAP_HI) begin
        vec_hi_byte <= vec_data_i;
      end
      pc_load_o <= (state == riv_pkg::S_SEQ) && (cnt == `RIV_VEC_CAP_LO);
      if (state == riv_pkg::S_SEQ && cnt == `RIV_VEC_CAP_LO) begin
        pc_value_o <= {vec_hi_byte, vec_data_i};
      end
      run_o <= ((state == riv_pkg::S_SEQ) && (cnt == 5'h00)) ||
               ((state == riv_pkg::S_RUN) && !take);
    end
  end

  // Helper: cycles since the sequence began, for the timing checks
  always_ff @(posedge core_clk_i or negedge rst_q) begin
    if (!rst_q) begin
      seq_age <= 5'h00;
    end else if (ce_i) begin
      if (take) begin
        seq_age <= 5'h01;
      end else if (state == riv_pkg::S_SEQ) begin
        seq_age <= seq_age + 5'h01;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_q);

  sequence vec_hi_s(logic [15:0] a);
    ce_i && vec_rd_o && vec_addr_o == a;
  endsequence
  sequence vec_lo_s(logic [15:0] a);
    vec_rd_o && vec_addr_o == (a | 16'h0001);
  endsequence

  seq_length_a: assert property ($rose(run_o) |-> seq_age == seq_len)
    else $error("sequence length differs from expected");
  irq_length_a: assert property (ce_i && take && !idle_i |=> seq_len == 5'h13)
    else $error("interrupt sequence is not nineteen cycles");
  reset_vec_a: assert property (vec_hi_s(16'hfffe) ##1 ce_i |-> vec_lo_s(16'hfffe))
    else $error("reset vector low byte not read after high");
  reset_fetch_a: assert property (seq_first |-> seq_vec == 16'hfffe
                                  && st_clr_o && sp_load_o)
    else $error("release did not clear status or aim at reset vector");
  stack_init_a: assert property (sp_load_o |-> sp_value_o == 8'h01)
    else $error("stack pointer not loaded with one");
  pc_save_a: assert property (ce_i && seq_first |=> saved_load_o
                              && saved_pc_high_reg_o == $past(pc_shadow[15:8]))
    else $error("old program counter not saved");
  prio_order_a: assert property (take && req[0] |-> win_idx == 3'h0)
    else $error("priority one not served first");
  gate_req_a: assert property (take |-> gie_i && irq_en[win_idx]
                               && irq_pending_flag_o[win_idx])
    else $error("interrupt taken while masked");
  ack_steps_a: assert property (ce_i && take |=> push_o && st_clr_o && !run_o)
    else $error("acknowledge did not push and clear status");
  clr_write_a: assert property (ce_i && wr_clr[3] && !set_ev[3]
                                |=> !irq_pending_flag_o[3])
    else $error("clear bit write did not clear the flag");
  en_release_a: assert property (seq_first |-> irq_en == 5'h00)
    else $error("enables not zero after release");
  no_run_a: assert property (state == riv_pkg::S_SEQ && cnt != 5'h00 |=> !run_o)
    else $error("core released before sequence end");
endmodule : riv_top
`default_nettype wire

//--- tb/riv_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module riv_core_model (
  input  wire logic        clk_i,
  input  wire logic        vec_rd_i,
  input  wire logic [15:0] vec_addr_i,
  output logic      [7:0]  vec_data_o
);
  // Program memory: a byte follows each read request one cycle later.
  // Between reads the bus shows the inverse of its last value, so a
  // capture in the wrong cycle cannot pass for a valid one.
  always_ff @(posedge clk_i) begin
    if (vec_rd_i) begin
      vec_data_o <= vec_addr_i[7:0] ^ 8'h3c;
    end else begin
      vec_data_o <= ~vec_data_o;
    end
  end
endmodule : riv_core_model
`default_nettype wire

//--- tb/reset_interrupt_vectoring_test.sv
`timescale 1ns/10ps
`default_nettype none
module reset_interrupt_vectoring_test;
  // Inputs driven by the bench
  logic        clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, gie = 1'b0, bnd = 1'b0, idle = 1'b0;
  logic        w1 = 1'b0, w2 = 1'b0, ce = 1'b1;  // ce is the clock enable
  logic [1:0]  pin_n = 2'b11;  // Pins one and three, active low
  logic [4:0]  src = 5'h00;    // Pulses tx, rx, timer three, timer two, timer one
  logic [7:0]  d1 = 8'h00, d2 = 8'h00, vdat;
  logic [15:0] pc = 16'h0000;
  // Outputs of the block
  logic [7:0]  r1, r2, sph, spl, spv, pbv;
  logic [4:0]  flg;
  logic [2:0]  code;
  logic [15:0] vaddr, pcv;
  logic        ddr, pa, pcd, pbf, run, stc, psh, spld, svld, vrd, pld, ack;
  int          err_count = 0, comparisons = 0, n;

  initial forever #50 clk = ~clk;  // 10 MHz state clock

  riv_top u_riv_top (
    .core_clk_i(clk), .rst_n_i(rst_n), .por_n_i(por_n), .ce_i(ce),
    .ext_irq_one_n_i(pin_n[0]), .ext_irq_three_n_i(pin_n[1]),
    .timer_one_uf_i(src[0]), .timer_two_uf_i(src[1]), .timer_three_uf_i(src[2]),
    .rx_loaded_i(src[3]), .tx_empty_i(src[4]), .gie_i(gie), .boundary_i(bnd),
    .idle_i(idle), .pc_i(pc), .vec_data_i(vdat), .ctl_first_wr_i(w1),
    .ctl_first_wdata_i(d1), .ctl_second_wr_i(w2), .ctl_second_wdata_i(d2),
    .ctl_first_rdata_o(r1), .ctl_second_rdata_o(r2), .irq_pending_flag_o(flg),
    .ddr_clear_o(ddr), .port_a_set_o(pa), .port_cd_set_o(pcd), .port_b_force_o(pbf),
    .port_b_value_o(pbv), .run_o(run), .st_clr_o(stc), .push_o(psh), .sp_load_o(spld),
    .sp_value_o(spv), .saved_load_o(svld), .saved_pc_high_reg_o(sph),
    .saved_pc_low_reg_o(spl), .vec_rd_o(vrd), .vec_addr_o(vaddr), .pc_load_o(pld),
    .pc_value_o(pcv), .irq_ack_o(ack), .irq_code_o(code)
  );

  riv_core_model u_riv_core_model (
    .clk_i(clk), .vec_rd_i(vrd), .vec_addr_i(vaddr), .vec_data_o(vdat)
  );

  // Verdict in one place
  task automatic tally_and_finish;
    $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Compare and count; wide enough for packed groups of outputs
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Control register write: taken at the edge where the strobe is high
  task automatic wr(input bit sec, input logic [7:0] d);
    @(posedge clk);
    if (sec) begin
      w2 <= 1'b1;
      d2 <= d;
    end else begin
      w1 <= 1'b1;
      d1 <= d;
    end
    @(posedge clk);
    w1 <= 1'b0;
    w2 <= 1'b0;
  endtask : wr

  // One-cycle pulse on the peripheral request lines
  task automatic pulse(input logic [4:0] s);
    @(posedge clk);
    src <= s;
    @(posedge clk);
    src <= 5'h00;
  endtask : pulse

  // Counts edges from the launching edge until run returns; bounded
  task automatic seq(input logic [15:0] base, input int len, input logic [2:0] idx,
                     input bit irq);
    logic [15:0] got;
    n   = 0;
    got = 16'h0000;
    do begin
      @(posedge clk);
      bnd  <= 1'b0;
      idle <= 1'b0;
      #1 n++;
      if (pld === 1'b1) got = pcv;
      if (irq && n == 1) check({ack, psh, stc, run, code}, {4'b1110, idx});
      if (!irq && n == 3) check(svld, 1'b1);
      if (n > 40) begin
        err_count++;
        tally_and_finish();
      end
    end while (run !== 1'b1);
    check(n, len);
    check(got, {base[7:0] ^ 8'h3c, base[7:0] ^ 8'h3d});
  endtask : seq

  // Hold reset six cycles, check the held state, then the start-up walk
  task automatic do_reset(input bit pw);
    @(posedge clk);
    rst_n <= 1'b0;
    por_n <= ~pw;
    repeat (6) @(posedge clk);
    #1 check({ddr, pa, pcd, pbf, run, stc, spld}, 7'b1111011);
    check({pbv, spv}, 16'hff01);
    @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    seq(16'hfffe, 19, 3'h0, 1'b0);
    check({ddr, pa, pcd, pbf, stc, spld}, 6'h00);
  endtask : do_reset

  initial begin
    do_reset(1'b1);
    check({r1, r2, flg}, 21'h0);
    // Raise every source while all enables are still zero
    @(posedge clk);
    pin_n <= 2'b00;
    pulse(5'h07);
    repeat (8) @(posedge clk);
    pin_n <= 2'b11;
    gie   <= 1'b1;
    // A boundary with enables off, then one with global enable off
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(1'b0, 8'h15);
      if (k == 1) wr(1'b1, 8'h05);
      @(posedge clk);
      gie <= (k == 0);
      bnd <= 1'b1;
      @(posedge clk);
      bnd <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check({flg, run}, 6'h3f);
    end
    gie <= 1'b1;
    // All five pending: served one per boundary, highest first
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      bnd <= 1'b1;
      seq(16'hfffc - 16'(2 * i), 19, 3'(i), 1'b1);
      check(flg, 5'(5'h1e << i));
    end
    // Receive request taken out of the idle state
    pulse(5'h08);
    idle <= 1'b1;
    seq(16'hfff6, 17, 3'h3, 1'b1);
    // Clear by writing one, no effect from writing zero
    pulse(5'h10);
    wr(1'b1, 8'h07);
    pulse(5'h02);
    wr(1'b1, 8'h05);
    @(posedge clk);
    #1 check({flg, r2}, {5'h10, 8'h0d});
    // A timer pulse while the clock enable is low must not be latched
    ce <= 1'b0;
    pulse(5'h01);
    ce <= 1'b1;
    #1 check(flg, 5'h10);
    // Mid-run reset keeps flags and saves the running address
    pc <= 16'h12ab;
    do_reset(1'b0);
    check({sph, spl, flg, r1, r2}, {16'h12ab, 5'h10, 8'h00, 8'h08});
    tally_and_finish();
  end
endmodule : reset_interrupt_vectoring_test
`default_nettype wire
